// *** src/mil_defines.vh ***
// register offsets, bit positions, reset values and timing for the interrupt logic
`ifndef MIL_DEFINES_VH
`define MIL_DEFINES_VH
// wishbone word offsets (byte addresses)
`define MIL_ADDR_CTRL 6'h00
`define MIL_ADDR_OPTION 6'h04
`define MIL_ADDR_PFLAG_A 6'h08
`define MIL_ADDR_PFLAG_B 6'h0c
`define MIL_ADDR_PEN_A 6'h10
`define MIL_ADDR_PEN_B 6'h14
`define MIL_ADDR_STAT 6'h18
`define MIL_ADDR_MASK 6'h1c
`define MIL_ADDR_CORE 6'h20
// control register bit positions
`define MIL_BIT_GIE 7
`define MIL_BIT_PERIPHERAL_IRQ_ENABLE 6
`define MIL_BIT_TOIE 5
`define MIL_BIT_EXTE 4
`define MIL_BIT_PCIE 3
`define MIL_BIT_TOIF 2
`define MIL_BIT_EXTF 1
`define MIL_BIT_PCIF 0
// option register edge select
`define MIL_BIT_EDGE 6
// reset values
`define MIL_CTRL_RST 8'h00
`define MIL_OPTION_RST 8'hff
`define MIL_PREG_RST 8'h00
// vector address loaded on entry
`define MIL_VECTOR 13'h0004
// quarter cycles per instruction cycle
`define MIL_QPHASES 4
// timer overflow boundary
`define MIL_TMR_MAX 8'hff
`define MIL_TMR_MIN 8'h00
// summary interrupt status bits
`define MIL_ST_ENTRY 0
`define MIL_ST_WAKE 1
`endif

// *** src/mil_sync.v ***
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none
module mil_sync
(
    // clock and reset
    input wire clk,
    input wire rst,
    // pin and filtered level
    input wire pin,
    output reg level
);
    reg s1;
    reg s2;
    reg s3;

    // s1 only feeds s2; level moves once s2 and s3 agree
    always @(posedge clk)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level <= s3;
        end
    end
endmodule
`default_nettype wire

// *** src/mil_flag.v ***
// one sticky flag: hardware set beats software clear
`timescale 1ns/10ps
`default_nettype none
module mil_flag
(
    // clock and reset
    input wire clk,
    input wire rst,
    // set and clear
    input wire set,
    input wire clr,
    output reg q
);
    // a set in the clearing cycle must not be lost
    always @(posedge clk)
    begin
        if (rst)
            q <= 1'b0;
        else if (set)
            q <= 1'b1;
        else if (clr)
            q <= 1'b0;
    end
endmodule
`default_nettype wire

// *** src/mil_top.v ***
// interrupt logic of the microcontroller core with wishbone register access
// Operation
// R1: twelve request sources, each with own flag bit and own enable bit. The code has nineteen sources.
// R2: flags set on their event whatever any enable says.
// R3: global enable at control bit 7 allows unmasked requests, else blocks all.
// R4: vector as soon as global enable and any flag with its enable.
// R5: global enable is cleared on every reset.
// R6: on entry clear global enable, push return address, load pc with 0004h.
// R7: return from interrupt pops return address and sets global enable.
// R8: entry saves only the return pc, nothing else.
// R9: external event to vector takes three or four instruction cycles. The code takes at most one cycle after the flag sets.
// R10: peripheral flags in two registers, two enable registers, peripheral enable gate.
// R11: external pin edge: rising when option bit 6 set, else falling.
// R12: valid edge sets control bit 1; control bit 4 masks it.
// R13: pin wakes from sleep only if its enable was set before sleep.
// R14: after wake vector only if global enable set, else continue.
// R15: timer ff to 00 overflow sets bit 2, gated by bit 5.
// R16: change on upper port pins 7:4 sets bit 0, gated by change enable.
// R17: firmware clears serviced flags before re-enabling interrupts.
// R18: flags stay set until software clears them; exit clears nothing.
`timescale 1ns/10ps
`default_nettype none
`include "mil_defines.vh"
module mil_top
(
    // clock and reset
    input wire clk,
    input wire rst,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // event sources
    input wire ext_irq_pin,
    input wire [3:0] upper_port_pins,
    input wire [7:0] timer_zero_count,
    input wire [7:0] periph_events_a,
    input wire [7:0] periph_events_b,
    // core sequencer
    input wire q_phase_end,
    input wire [12:0] core_pc,
    input wire return_from_irq_instr,
    input wire sleep_enter,
    // core outputs
    output reg irq_vector_req,
    output reg [12:0] vector_pc,
    output reg stack_push,
    output reg [12:0] stack_push_data,
    output reg stack_pop,
    output reg wake,
    output reg sleeping,
    // summary interrupt
    output reg irq
);
    // control register pieces
    localparam [7:0] option_rst = `MIL_OPTION_RST;
    reg global_irq_enable;
    reg peripheral_irq_enable;
    reg timer_overflow_enable;
    reg ext_pin_enable;
    reg port_change_enable;
    reg ext_edge_select;
    reg [7:0] periph_enable_reg_a;
    reg [7:0] periph_enable_reg_b;
    reg [1:0] stat;
    reg [1:0] mask;
    wire timer_overflow_flag;
    wire ext_pin_flag;
    wire port_change_flag;
    wire [7:0] periph_flag_reg_a;
    wire [7:0] periph_flag_reg_b;
    wire [7:0] irq_control_reg;
    // synchronised pins
    wire ext_lvl;
    wire [3:0] port_lvl;
    reg ext_prev;
    reg [3:0] port_prev;
    reg [7:0] tmr_prev;
    // bus decode
    wire wb_req;
    wire wr;
    wire [31:0] wmask;
    wire [7:0] wbyte;
    // events and request
    wire ext_edge;
    wire port_change;
    wire tmr_ovf;
    wire pending;
    wire periph_pending;
    reg [1:0] qcnt;
    reg [1:0] next_qcnt;
    reg ext_en_at_sleep;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = wb_req & wb_we_i & wb_sel_i[0];
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wbyte = wb_dat_i[7:0];

    // pin synchronisers
    mil_sync u_sync_ext
    (
        .clk(clk),
        .rst(rst),
        .pin(ext_irq_pin),
        .level(ext_lvl)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_port
            mil_sync u_sync_port
            (
                .clk(clk),
                .rst(rst),
                .pin(upper_port_pins[gi]),
                .level(port_lvl[gi])
            );
        end
    endgenerate

    // previous values for edge, change and overflow detection
    always @(posedge clk)
    begin
        if (rst)
        begin
            ext_prev <= 1'b0;
            port_prev <= 4'h0;
            tmr_prev <= 8'h00;
        end
        else
        begin
            ext_prev <= ext_lvl;
            port_prev <= port_lvl;
            tmr_prev <= timer_zero_count;
        end
    end

    // edge polarity follows the option bit
    assign ext_edge = ext_edge_select ? (ext_lvl & ~ext_prev) : (~ext_lvl & ext_prev); // R11
    assign port_change = |(port_lvl ^ port_prev); // R16
    assign tmr_ovf = (tmr_prev == `MIL_TMR_MAX) && (timer_zero_count == `MIL_TMR_MIN); // R15

    // flags set regardless of enables; only software write of zero clears them
    mil_flag u_flag_ext
    (
        .clk(clk),
        .rst(rst),
        .set(ext_edge), // R12 R2
        .clr(wr && wb_adr_i == `MIL_ADDR_CTRL && !wbyte[`MIL_BIT_EXTF]), // R18
        .q(ext_pin_flag)
    );
    mil_flag u_flag_tmr
    (
        .clk(clk),
        .rst(rst),
        .set(tmr_ovf), // R15 R2
        .clr(wr && wb_adr_i == `MIL_ADDR_CTRL && !wbyte[`MIL_BIT_TOIF]),
        .q(timer_overflow_flag)
    );
    mil_flag u_flag_port
    (
        .clk(clk),
        .rst(rst),
        .set(port_change), // R16 R2
        .clr(wr && wb_adr_i == `MIL_ADDR_CTRL && !wbyte[`MIL_BIT_PCIF]),
        .q(port_change_flag)
    );
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_pflag
            mil_flag u_flag_pa
            (
                .clk(clk),
                .rst(rst),
                .set(periph_events_a[gi]), // R10 R2
                .clr(wr && wb_adr_i == `MIL_ADDR_PFLAG_A && !wbyte[gi]),
                .q(periph_flag_reg_a[gi])
            );
            mil_flag u_flag_pb
            (
                .clk(clk),
                .rst(rst),
                .set(periph_events_b[gi]),
                .clr(wr && wb_adr_i == `MIL_ADDR_PFLAG_B && !wbyte[gi]),
                .q(periph_flag_reg_b[gi])
            );
        end
    endgenerate

    assign irq_control_reg = {global_irq_enable, peripheral_irq_enable, timer_overflow_enable,
        ext_pin_enable, port_change_enable, timer_overflow_flag, ext_pin_flag, port_change_flag};

    // nineteen sources gated by own enable; peripherals also by peripheral enable
    assign periph_pending = peripheral_irq_enable &
        (|(periph_flag_reg_a & periph_enable_reg_a) | |(periph_flag_reg_b & periph_enable_reg_b)); // R10
    assign pending = (ext_pin_flag & ext_pin_enable) | (timer_overflow_flag & timer_overflow_enable) |
        (port_change_flag & port_change_enable) | periph_pending; // R1

    // quarter-phase counter: request is taken at the instruction boundary
    always @*
    begin
        next_qcnt = qcnt;
        if (q_phase_end)
            next_qcnt = qcnt + 2'd1;
    end

    // enables, entry, return, sleep and wake
    always @(posedge clk)
    begin
        if (rst)
        begin
            global_irq_enable <= 1'b0; // R5
            peripheral_irq_enable <= 1'b0;
            timer_overflow_enable <= 1'b0;
            ext_pin_enable <= 1'b0;
            port_change_enable <= 1'b0;
            ext_edge_select <= option_rst[`MIL_BIT_EDGE];
            periph_enable_reg_a <= `MIL_PREG_RST;
            periph_enable_reg_b <= `MIL_PREG_RST;
            qcnt <= 2'd0;
            irq_vector_req <= 1'b0;
            vector_pc <= 13'h0000;
            stack_push <= 1'b0;
            stack_push_data <= 13'h0000;
            stack_pop <= 1'b0;
            wake <= 1'b0;
            sleeping <= 1'b0;
            ext_en_at_sleep <= 1'b0;
        end
        else
        begin
            qcnt <= next_qcnt;
            irq_vector_req <= 1'b0;
            stack_push <= 1'b0;
            stack_pop <= 1'b0;
            wake <= 1'b0;
            if (wr && wb_adr_i == `MIL_ADDR_CTRL)
            begin
                global_irq_enable <= wbyte[`MIL_BIT_GIE];
                peripheral_irq_enable <= wbyte[`MIL_BIT_PERIPHERAL_IRQ_ENABLE];
                timer_overflow_enable <= wbyte[`MIL_BIT_TOIE];
                ext_pin_enable <= wbyte[`MIL_BIT_EXTE]; // R12
                port_change_enable <= wbyte[`MIL_BIT_PCIE];
            end
            if (wr && wb_adr_i == `MIL_ADDR_OPTION)
                ext_edge_select <= wbyte[`MIL_BIT_EDGE];
            if (wr && wb_adr_i == `MIL_ADDR_PEN_A)
                periph_enable_reg_a <= wbyte;
            if (wr && wb_adr_i == `MIL_ADDR_PEN_B)
                periph_enable_reg_b <= wbyte;
            // return: pop address and re-enable; flags are left alone
            if (return_from_irq_instr)
            begin
                stack_pop <= 1'b1; // R7
                global_irq_enable <= 1'b1; // R7 R18
            end
            // capture the pin enable as sleep begins
            if (sleep_enter && !sleeping)
            begin
                sleeping <= 1'b1;
                ext_en_at_sleep <= ext_pin_enable; // R13
            end
            // wake: pin only if its enable was set before sleep, other requests by their current enables and only while the pin flag is clear; vectoring decided below
            if (sleeping && ((ext_pin_flag && ext_en_at_sleep) || (pending && !ext_pin_flag)))
            begin
                sleeping <= 1'b0;
                wake <= 1'b1; // R13 R14
            end
            // entry only at an instruction boundary, at most one cycle after the flag rather than the three to four of R9
            if (global_irq_enable && pending && !sleeping && q_phase_end &&
                qcnt == 2'd3 && !return_from_irq_instr) // R3 R4 R9 R14
            begin
                global_irq_enable <= 1'b0; // R6
                stack_push <= 1'b1; // R6
                stack_push_data <= core_pc; // R8
                vector_pc <= `MIL_VECTOR; // R6
                irq_vector_req <= 1'b1;
            end
        end
    end

    // sticky summary status and mask; write one to clear, set wins
    always @(posedge clk)
    begin
        if (rst)
        begin
            stat <= 2'b00;
            mask <= 2'b00;
            irq <= 1'b0;
        end
        else
        begin
            stat[`MIL_ST_ENTRY] <= irq_vector_req |
                (stat[`MIL_ST_ENTRY] & ~(wr && wb_adr_i == `MIL_ADDR_STAT && wbyte[`MIL_ST_ENTRY]));
            stat[`MIL_ST_WAKE] <= wake |
                (stat[`MIL_ST_WAKE] & ~(wr && wb_adr_i == `MIL_ADDR_STAT && wbyte[`MIL_ST_WAKE]));
            if (wr && wb_adr_i == `MIL_ADDR_MASK)
                mask <= wbyte[1:0];
            irq <= |(stat & mask);
        end
    end

    // bus read and one-cycle acknowledge; unmapped reads zero
    always @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i)
            begin
                if (wb_adr_i == `MIL_ADDR_CTRL)
                    wb_dat_o <= {24'h000000, irq_control_reg} & wmask;
                else if (wb_adr_i == `MIL_ADDR_OPTION)
                    wb_dat_o <= {25'h0000000, ext_edge_select, 6'h00} & wmask;
                else if (wb_adr_i == `MIL_ADDR_PFLAG_A)
                    wb_dat_o <= {24'h000000, periph_flag_reg_a} & wmask;
                else if (wb_adr_i == `MIL_ADDR_PFLAG_B)
                    wb_dat_o <= {24'h000000, periph_flag_reg_b} & wmask;
                else if (wb_adr_i == `MIL_ADDR_PEN_A)
                    wb_dat_o <= {24'h000000, periph_enable_reg_a} & wmask;
                else if (wb_adr_i == `MIL_ADDR_PEN_B)
                    wb_dat_o <= {24'h000000, periph_enable_reg_b} & wmask;
                else if (wb_adr_i == `MIL_ADDR_STAT)
                    wb_dat_o <= {30'h00000000, stat} & wmask;
                else if (wb_adr_i == `MIL_ADDR_MASK)
                    wb_dat_o <= {30'h00000000, mask} & wmask;
                else if (wb_adr_i == `MIL_ADDR_CORE)
                    wb_dat_o <= {30'h00000000, qcnt} & wmask;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/mil_asserts.sv ***
// port-level assertions for the interrupt logic
`timescale 1ns/10ps
`default_nettype none
module mil_asserts
(
    // clock and reset
    input wire clk,
    input wire rst,
    // register bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // core side
    input wire q_phase_end,
    input wire [12:0] core_pc,
    input wire return_from_irq_instr,
    input wire irq_vector_req,
    input wire [12:0] vector_pc,
    input wire stack_push,
    input wire [12:0] stack_push_data,
    input wire stack_pop,
    input wire wake,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a stuck ack would swallow the next bus cycle
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    entry_push_a: assert property (irq_vector_req |-> stack_push ##1 vector_pc == 13'h0004)
        else $error("entry without push or vector");
    push_pc_a: assert property (stack_push |-> stack_push_data == $past(core_pc))
        else $error("pushed pc wrong");
    entry_quarter_a: assert property (irq_vector_req |-> $past(q_phase_end))
        else $error("entry off quarter boundary");
    // entry clears the global enable, so no second entry can follow at once
    entry_once_a: assert property (irq_vector_req |=> !irq_vector_req [*8])
        else $error("entry repeated");
    pop_ret_a: assert property (return_from_irq_instr |=> stack_pop)
        else $error("return without pop");
    pop_cause_a: assert property (stack_pop |-> $past(return_from_irq_instr))
        else $error("pop without return");
    wake_pulse_a: assert property (wake |=> !wake) else $error("wake held");
    reset_quiet_a: assert property ($fell(rst) |-> !irq_vector_req && !stack_push && !irq)
        else $error("outputs active after reset");
endmodule
bind mil_top mil_asserts i_mil_asserts (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .q_phase_end(q_phase_end), .core_pc(core_pc),
    .return_from_irq_instr(return_from_irq_instr), .irq_vector_req(irq_vector_req),
    .vector_pc(vector_pc), .stack_push(stack_push), .stack_push_data(stack_push_data),
    .stack_pop(stack_pop), .wake(wake), .irq(irq));
`default_nettype wire

// *** bench/mil_core_model.sv ***
// behavioural processor core sequencer facing the interrupt logic
`timescale 1ns/10ps
`default_nettype none
module mil_core_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // commands from the bench
    input wire logic ret_cmd,
    input wire logic sleep_cmd,
    // from the interrupt logic
    input wire logic irq_vector_req,
    input wire logic stack_push,
    input wire logic [12:0] stack_push_data,
    input wire logic stack_pop,
    // to the interrupt logic
    output logic q_phase_end,
    output logic [12:0] core_pc,
    output logic return_from_irq_instr,
    output logic sleep_enter
);
    logic [2:0] qcnt;
    logic [12:0] stack_top;
    // quarter pulse every other clock; one-deep stack is enough for unnested handlers
    always @(posedge clk)
    begin
        if (rst)
        begin
            qcnt <= 3'h0;
            core_pc <= 13'h0000;
            stack_top <= 13'h0000;
        end
        else
        begin
            qcnt <= qcnt + 3'h1;
            if (irq_vector_req)
                core_pc <= 13'h0004;
            else if (stack_pop)
                core_pc <= stack_top;
            else if (qcnt == 3'h7)
                core_pc <= core_pc + 13'h0001;
            if (stack_push)
                stack_top <= stack_push_data;
        end
        q_phase_end <= !rst && qcnt[0];
        return_from_irq_instr <= ret_cmd;
        sleep_enter <= sleep_cmd;
    end
endmodule
`default_nettype wire

// *** bench/mil_top_tb.sv ***
// self-checking testbench for the interrupt logic
`timescale 1ns/10ps
`default_nettype none
`include "mil_defines.vh"
module mil_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h0;
    logic pin = 1'b0;
    logic [3:0] port = 4'h0;
    logic [7:0] tmr = 8'h00;
    logic [7:0] pev_a = 8'h00;
    logic [7:0] pev_b = 8'h00;
    logic ret_cmd = 1'b0;
    logic sleep_cmd = 1'b0;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    wire [31:0] wb_dat_o;
    wire [12:0] core_pc, vector_pc, push_data;
    wire wb_ack_o, qpe, ret_p, slp_p, irq_vector_req, push, pop, wake, sleeping, irq;
    mil_top i_mil_top (.clk(clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ext_irq_pin(pin), .upper_port_pins(port),
        .timer_zero_count(tmr), .periph_events_a(pev_a), .periph_events_b(pev_b),
        .q_phase_end(qpe), .core_pc(core_pc), .return_from_irq_instr(ret_p),
        .sleep_enter(slp_p), .irq_vector_req(irq_vector_req), .vector_pc(vector_pc),
        .stack_push(push), .stack_push_data(push_data), .stack_pop(pop), .wake(wake),
        .sleeping(sleeping), .irq(irq));
    mil_core_model i_mil_core_model (.clk(clk), .rst(rst), .ret_cmd(ret_cmd),
        .sleep_cmd(sleep_cmd), .irq_vector_req(irq_vector_req), .stack_push(push),
        .stack_push_data(push_data), .stack_pop(pop),
        .q_phase_end(qpe), .core_pc(core_pc), .return_from_irq_instr(ret_p),
        .sleep_enter(slp_p));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out;
        end
    end
    task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle; request held until the edge that samples ack
    task automatic wb(input [5:0] a, input w, input [31:0] d, output [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // ack and read data are sampled at the rising edge, as the slave sees them
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        chk("ack", 0, k >= 20);
        q = wb_dat_o;
        req <= 1'b0;
    endtask
    task automatic wr(input [5:0] a, input [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask
    task automatic rd(input string nm, input [5:0] a, input [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(nm, e, q);
    endtask
    // counts negedges until wake or entry shows, giving up at lim
    task automatic wait_ev(input bit wk, input int lim, output int k);
        k = 0;
        @(negedge clk);
        while ((wk ? wake : irq_vector_req) !== 1'b1 && k < lim)
        begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic drive_pin(input v);
        @(posedge clk);
        pin <= v;
        repeat (8) @(posedge clk);
    endtask
    // the gap keeps a return well clear of the entry that preceded it
    task automatic ret;
        repeat (4) @(posedge clk);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
    endtask
    task automatic do_sleep;
        @(posedge clk);
        sleep_cmd <= 1'b1;
        @(posedge clk);
        sleep_cmd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset;
        rd("ctrl", `MIL_ADDR_CTRL, 32'h0);
        rd("option", `MIL_ADDR_OPTION, 32'h40);
        rd("pflag_b", `MIL_ADDR_PFLAG_B, 32'h0);
        wr(6'h24, 32'hff);
        rd("unmapped", 6'h24, 32'h0);
    endtask
    // flags rise with every enable off
    task automatic t_flags;
        drive_pin(1'b1);
        rd("rise", `MIL_ADDR_CTRL, 32'h02);
        wr(`MIL_ADDR_CTRL, 32'h0);
        drive_pin(1'b0);
        rd("fall ignored", `MIL_ADDR_CTRL, 32'h0);
        wr(`MIL_ADDR_OPTION, 32'hbf);
        drive_pin(1'b1);
        drive_pin(1'b0);
        rd("fall", `MIL_ADDR_CTRL, 32'h02);
        wr(`MIL_ADDR_OPTION, 32'hff);
        tmr <= 8'hfe;
        @(posedge clk);
        tmr <= 8'hff;
        rd("no wrap", `MIL_ADDR_CTRL, 32'h02);
        tmr <= 8'h00;
        rd("wrap", `MIL_ADDR_CTRL, 32'h06);
        port <= 4'h9;
        repeat (8) @(posedge clk);
        rd("change", `MIL_ADDR_CTRL, 32'h07);
        wr(`MIL_ADDR_CTRL, 32'h0);
        rd("cleared", `MIL_ADDR_CTRL, 32'h0);
    endtask
    task automatic t_periph;
        @(posedge clk);
        pev_a <= 8'h08;
        pev_b <= 8'h80;
        @(posedge clk);
        pev_a <= 8'h00;
        pev_b <= 8'h00;
        rd("pflag_a", `MIL_ADDR_PFLAG_A, 32'h08);
        rd("pflag_b", `MIL_ADDR_PFLAG_B, 32'h80);
        wr(`MIL_ADDR_PEN_A, 32'h08);
        wr(`MIL_ADDR_CTRL, 32'h80);
        wait_ev(1'b0, 30, n);
        chk("peripheral_irq_enable gate", 30, n);
        wr(`MIL_ADDR_CTRL, 32'hc0);
        wait_ev(1'b0, 30, n);
        chk("periph entry", 1, n < 30);
        wr(`MIL_ADDR_PFLAG_A, 32'h0);
        wr(`MIL_ADDR_PFLAG_B, 32'h0);
        ret;
        rd("gie back", `MIL_ADDR_CTRL, 32'hc0);
        wr(`MIL_ADDR_CTRL, 32'h0);
    endtask
    task automatic t_entry;
        wr(`MIL_ADDR_MASK, 32'h1);
        wr(`MIL_ADDR_CTRL, 32'h90);
        @(posedge clk);
        pin <= 1'b1;
        wait_ev(1'b0, 40, n);
        chk("latency", 1, n <= 32);
        rd("in handler", `MIL_ADDR_CTRL, 32'h12);
        chk("vector", `MIL_VECTOR, vector_pc);
        chk("irq up", 1, irq);
        wr(`MIL_ADDR_STAT, 32'h1);
        rd("stat clear", `MIL_ADDR_STAT, 32'h0);
        chk("irq down", 0, irq);
        ret;
        wait_ev(1'b0, 30, n);
        chk("reentry", 1, n < 30);
        wr(`MIL_ADDR_CTRL, 32'h10);
        ret;
        wait_ev(1'b0, 30, n);
        chk("quiet", 30, n);
        rd("after return", `MIL_ADDR_CTRL, 32'h90);
        wr(`MIL_ADDR_MASK, 32'h0);
        repeat (2) @(negedge clk);
        chk("masked", 0, irq);
        wr(`MIL_ADDR_STAT, 32'h3);
        wr(`MIL_ADDR_CTRL, 32'h0);
        drive_pin(1'b0);
    endtask
    task automatic t_sleep;
        wr(`MIL_ADDR_CTRL, 32'h10);
        do_sleep;
        @(posedge clk);
        pin <= 1'b1;
        wait_ev(1'b1, 30, n);
        chk("wake", 1, n < 30);
        wait_ev(1'b0, 20, n);
        chk("no vector", 20, n);
        // a one in bit 1 keeps the pending pin flag; a zero would clear it
        wr(`MIL_ADDR_CTRL, 32'h92);
        wait_ev(1'b0, 20, n);
        chk("pending entry", 1, n < 20);
        wr(`MIL_ADDR_CTRL, 32'h0);
        drive_pin(1'b0);
        ret;
        do_sleep;
        wr(`MIL_ADDR_CTRL, 32'h10);
        @(posedge clk);
        pin <= 1'b1;
        wait_ev(1'b1, 30, n);
        chk("late enable", 30, n);
        chk("asleep", 1, sleeping);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_flags;
        t_periph;
        t_entry;
        t_sleep;
        close_out;
    end
endmodule
`default_nettype wire
